// ### watchdog.sv
/*
 * Watchdog timer behind the general-purpose level registers, plus the board
 * power-fail handling. Assumes a register access port from the I/O decoder on
 * the same clock, and pins for power good and undervoltage from outside.
 */
`timescale 1ns/10ps
module watchdog #(
  parameter longint unsigned MS_SCALE = 1
) (
  // Clock and reset.
  input  wire logic                       clock,
  input  wire logic                       nrst,
  // Register access.
  input  wire watchdog_pkg::reg_req_s     req,
  output logic [31:0]                     rdata,
  output logic                            rvalid,
  // Board pins.
  input  wire logic                       power_good,
  input  wire logic                       undervoltage,
  // Outputs.
  output logic                            sys_reset,
  output logic                            system_mgmt_interrupt_low,
  output logic                            expired
);

  watchdog_pkg::wd_regs_s q_ff;
  watchdog_pkg::wd_regs_s nxt_q;
  logic [1:0] pg_sync_ff;
  logic [1:0] uv_sync_ff;
  logic       pg_prev_ff;
  logic [2:0] sel;
  logic       enable_low;
  logic       kick;
  logic       active;
  watchdog_pkg::count_t period;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pg_sync_ff <= 2'h0;
      uv_sync_ff <= 2'h0;
      pg_prev_ff <= 1'b0;
    end else begin
      pg_sync_ff <= {pg_sync_ff[0], power_good};
      uv_sync_ff <= {uv_sync_ff[0], undervoltage};
      pg_prev_ff <= pg_sync_ff[1];
    end
  end

  assign enable_low = q_ff.lvl_b[watchdog_pkg::BIT_ENABLE_LOW];
  assign sel        = q_ff.lvl_c[watchdog_pkg::BIT_SEL2:watchdog_pkg::BIT_SEL0];
  assign kick       = q_ff.lvl_c[watchdog_pkg::BIT_KICK];
  assign active     = !enable_low && (sel != watchdog_pkg::SEL_OFF);

  always_comb begin
    unique case (sel)
      3'h0:    period = watchdog_pkg::count_t'(watchdog_pkg::MS_P0 * watchdog_pkg::CYC_PER_MS / MS_SCALE);
      3'h1:    period = watchdog_pkg::count_t'(watchdog_pkg::MS_P1 * watchdog_pkg::CYC_PER_MS / MS_SCALE);
      3'h2:    period = watchdog_pkg::count_t'(watchdog_pkg::MS_P2 * watchdog_pkg::CYC_PER_MS / MS_SCALE);
      3'h3:    period = watchdog_pkg::count_t'(watchdog_pkg::MS_P3 * watchdog_pkg::CYC_PER_MS / MS_SCALE);
      3'h4:    period = watchdog_pkg::count_t'(watchdog_pkg::MS_P4 * watchdog_pkg::CYC_PER_MS / MS_SCALE);
      3'h5:    period = watchdog_pkg::count_t'(watchdog_pkg::MS_P5 * watchdog_pkg::CYC_PER_MS / MS_SCALE);
      3'h6:    period = watchdog_pkg::count_t'(watchdog_pkg::MS_P6 * watchdog_pkg::CYC_PER_MS / MS_SCALE);
      default: period = '0;
    endcase
  end

  always_comb begin
    nxt_q           = q_ff;
    nxt_q.rvalid    = req.rd;
    nxt_q.kick_prev = kick;
    nxt_q.en_prev   = active;
    nxt_q.smi       = pg_prev_ff && !pg_sync_ff[1];
    nxt_q.uv_rst    = uv_sync_ff[1];
    if (req.wr) begin
      unique case (req.addr)
        watchdog_pkg::OFS_DIR_B: nxt_q.dir_b = req.wdata;
        watchdog_pkg::OFS_LVL_B: nxt_q.lvl_b = req.wdata;
        watchdog_pkg::OFS_DIR_C: nxt_q.dir_c = req.wdata;
        watchdog_pkg::OFS_LVL_C: nxt_q.lvl_c = req.wdata;
        default: ;
      endcase
    end
    unique case (req.addr)
      watchdog_pkg::OFS_DIR_B: nxt_q.rdata = q_ff.dir_b;
      watchdog_pkg::OFS_LVL_B: nxt_q.rdata = q_ff.lvl_b;
      watchdog_pkg::OFS_DIR_C: nxt_q.rdata = q_ff.dir_c;
      watchdog_pkg::OFS_LVL_C: nxt_q.rdata = q_ff.lvl_c;
      default:                 nxt_q.rdata = 32'h0000_0000;
    endcase
    nxt_q.sys_rst = 1'b0;
    unique case (q_ff.state)
      watchdog_pkg::WD_IDLE: begin
        if (active) begin
          nxt_q.state = watchdog_pkg::WD_RUN;
          nxt_q.count = period;
        end
      end
      watchdog_pkg::WD_RUN: begin
        if (!active) begin
          nxt_q.state = watchdog_pkg::WD_IDLE;
        end else if (kick != q_ff.kick_prev) begin
          nxt_q.count = period;
        end else if (q_ff.count <= watchdog_pkg::count_t'(1)) begin
          nxt_q.state   = watchdog_pkg::WD_EXPIRED;
          nxt_q.sys_rst = 1'b1;
        end else begin
          nxt_q.count = q_ff.count - watchdog_pkg::count_t'(1);
        end
      end
      watchdog_pkg::WD_EXPIRED: begin
        // Reset stays asserted until the system reset clears this block.
        nxt_q.sys_rst = 1'b1;
      end
      default: nxt_q.state = watchdog_pkg::WD_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      q_ff       <= '0;
      q_ff.state <= watchdog_pkg::WD_IDLE;
      q_ff.lvl_b <= watchdog_pkg::RST_LVL_B;
      q_ff.lvl_c <= watchdog_pkg::RST_LVL_C;
      q_ff.dir_b <= watchdog_pkg::RST_DIR_B;
      q_ff.dir_c <= watchdog_pkg::RST_DIR_C;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign rdata                     = q_ff.rdata;
  assign rvalid                    = q_ff.rvalid;
  assign sys_reset                 = q_ff.sys_rst || q_ff.uv_rst;
  assign system_mgmt_interrupt_low = !q_ff.smi;
  assign expired                   = q_ff.state == watchdog_pkg::WD_EXPIRED;

endmodule

// ### watchdog_pkg.sv
/*
 * Constants and types for the watchdog timer that software drives through the
 * general-purpose level registers of the I/O hub. Assumes a 250 MHz system clock.
 */
package watchdog_pkg;

  localparam int unsigned CLK_MHZ = 250;

  localparam logic [7:0] OFS_DIR_B = 8'h34;
  localparam logic [7:0] OFS_LVL_B = 8'h38;
  localparam logic [7:0] OFS_DIR_C = 8'h44;
  localparam logic [7:0] OFS_LVL_C = 8'h48;

  localparam int unsigned BIT_ENABLE_LOW = 15;
  localparam int unsigned BIT_SEL0       = 0;
  localparam int unsigned BIT_SEL2       = 2;
  localparam int unsigned BIT_KICK       = 7;

  // Power-on values: enable bit high, all watchdog lines as outputs.
  localparam logic [31:0] RST_LVL_B = 32'h0000_8000;
  localparam logic [31:0] RST_LVL_C = 32'h0000_0000;
  localparam logic [31:0] RST_DIR_B = 32'h0000_0000;
  localparam logic [31:0] RST_DIR_C = 32'h0000_0000;

  localparam logic [2:0] SEL_OFF = 3'h7;

  // Period figures in milliseconds.
  localparam longint unsigned MS_P0 = 32;
  localparam longint unsigned MS_P1 = 128;
  localparam longint unsigned MS_P2 = 512;
  localparam longint unsigned MS_P3 = 1000;
  localparam longint unsigned MS_P4 = 4000;
  localparam longint unsigned MS_P5 = 8000;
  localparam longint unsigned MS_P6 = 32000;
  localparam longint unsigned CYC_PER_MS = CLK_MHZ * 1000;

  localparam int unsigned CNT_W = 34;
  typedef logic [CNT_W-1:0] count_t;

  typedef enum logic [1:0] {
    WD_IDLE,
    WD_RUN,
    WD_EXPIRED
  } wd_state_e;

  // Register bus request from the I/O port decoder.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } reg_req_s;

  typedef struct packed {
    wd_state_e   state;
    count_t      count;
    logic        kick_prev;
    logic        en_prev;
    logic [31:0] lvl_b;
    logic [31:0] lvl_c;
    logic [31:0] dir_b;
    logic [31:0] dir_c;
    logic [31:0] rdata;
    logic        rvalid;
    logic        sys_rst;
    logic        smi;
    logic        uv_rst;
  } wd_regs_s;

endpackage

// ### watchdog_sva.sv
/* Port checker for the watchdog block.
   Bound to the watchdog top module from the test file. */
`timescale 1ns/10ps
module watchdog_sva (
  // Clock and reset.
  input wire logic                   clock,
  input wire logic                   nrst,
  // Register port.
  input wire watchdog_pkg::reg_req_s req,
  input wire logic [31:0]            rdata,
  input wire logic                   rvalid,
  // Pins.
  input wire logic                   power_good,
  input wire logic                   undervoltage,
  input wire logic                   sys_reset,
  input wire logic                   system_mgmt_interrupt_low,
  input wire logic                   expired
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence pg_drop;
    power_good ##1 !power_good;
  endsequence
  sequence uv_rise;
    !undervoltage ##1 undervoltage;
  endsequence
  a_read_answer: assert property (req.rd |=> rvalid) else $error("read not answered");
  a_no_stray: assert property (!req.rd |=> !rvalid) else $error("stray read answer");
  a_unmapped_zero: assert property (req.rd && !(req.addr inside {8'h34, 8'h38, 8'h44, 8'h48})
    |=> rdata == 32'h0000_0000) else $error("unmapped read not zero");
  a_expiry_latch: assert property (expired |=> expired) else $error("expiry dropped");
  a_expiry_reset: assert property (expired |-> sys_reset) else $error("expiry without reset");
  a_smi_raise: assert property (pg_drop |-> ##[1:4] !system_mgmt_interrupt_low)
    else $error("no interrupt on power loss");
  a_smi_pulse: assert property ($fell(system_mgmt_interrupt_low) |=> system_mgmt_interrupt_low)
    else $error("interrupt pulse too long");
  a_uv_reset: assert property (uv_rise |-> ##[1:4] sys_reset) else $error("no undervoltage reset");
endmodule

// ### watchdog_test.sv
/* Self-checking bench for the watchdog block.
   Periods are scaled so one millisecond is one clock cycle. */
`timescale 1ns/10ps
module watchdog_test;
  logic                   clock = 0;
  logic                   nrst = 0;
  logic                   power_good = 0;
  logic                   undervoltage = 0;
  watchdog_pkg::reg_req_s req = '0;
  logic [31:0]            rdata;
  logic                   rvalid;
  logic                   sys_reset;
  logic                   irq_low;
  logic                   expired;
  int                     n_fail = 0;
  int                     compares = 0;
  int                     cyc = 0;
  int                     ms[8] = '{32, 128, 512, 1000, 4000, 8000, 32000, 32};
  int                     regs[int];
  always #2 clock = ~clock;
  watchdog #(.MS_SCALE(250000)) dut_u (.clock(clock), .nrst(nrst), .req(req), .rdata(rdata), .rvalid(rvalid),
    .power_good(power_good), .undervoltage(undervoltage), .sys_reset(sys_reset),
    .system_mgmt_interrupt_low(irq_low), .expired(expired));
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wrap_up;
    if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock) req <= '{1'b1, 1'b0, a, d};
    @(posedge clock) req <= '0;
    if (regs.exists(a)) regs[a] = d;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clock) req <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge clock) req <= '0;
    #1;
    chk("rvalid", rvalid, 1'b1);
    chk("rdata", rdata, regs.exists(a) ? regs[a] : 0);
  endtask
  task rst;
    nrst <= 0;
    repeat (10) @(posedge clock);
    nrst <= 1;
    regs = '{8'h34: 0, 8'h38: 32'h0000_8000, 8'h44: 0, 8'h48: 0};
  endtask
  task run(input int s, input int en, input int kick);
    int p, k, n, e;
    p = ms[s];
    k = kick ? p / 4 + $urandom % (p / 2) : -1;
    n = 0;
    e = (en && s < 7) ? (kick ? k + 2 + p : p) : 2 * p + 50;
    rst();
    wr(8'h38, 32'h0000_8000);
    wr(8'h48, s);
    wr(8'h38, en ? 32'h0 : 32'h0000_8000);
    while (expired !== 1'b1 && n < 2 * p + 50) begin
      @(posedge clock);
      #1;
      n++;
      if (n == k) begin
        wr(8'h48, s | 32'h80);
        n += 2;
      end
    end
    chk("period", n >= e - 3 && n <= e + 3, 1'b1);
    chk("expired", expired, en && s < 7);
    chk("sys_reset", sys_reset, en && s < 7);
  endtask
  initial begin
    int seen;
    logic [7:0] a;
    void'($urandom(32'h055b_1113));
    rst();
    foreach (ms[i]) if (i < 5) rd(8'h34 + 8'(i[2:0]) * 8'h4);
    for (int i = 0; i < 4; i++) begin
      a = i[0] ? 8'h34 : 8'h44;
      wr(a, $urandom);
      rd(a);
    end
    wr(8'h44, regs[8'h44] & 32'hffff_ff78);
    wr(8'h34, regs[8'h34] & 32'hffff_7fff);
    rd(8'h44);
    chk("dir_c_lines", rdata & 32'h0000_0087, 32'h0000_0000);
    rd(8'h34);
    chk("dir_b_line", rdata & 32'h0000_8000, 32'h0000_0000);
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40);
    for (int s = 0; s < 8; s++) run(s, 1, 0);
    run(0, 0, 0);
    run(2, 1, 1);
    run(1, 1, 1);
    rst();
    @(posedge clock) power_good <= 1;
    repeat (6) @(posedge clock);
    power_good <= 0;
    seen = 0;
    repeat (8) begin
      @(posedge clock);
      #1;
      if (irq_low === 1'b0) seen++;
    end
    chk("smi", seen, 1);
    @(posedge clock) undervoltage <= 1;
    repeat (6) @(posedge clock);
    #1;
    chk("uv_reset", sys_reset, 1'b1);
    wrap_up();
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      wrap_up();
    end
  end
endmodule
bind watchdog watchdog_sva chk_u (.clock(clock), .nrst(nrst), .req(req), .rdata(rdata), .rvalid(rvalid),
  .power_good(power_good), .undervoltage(undervoltage), .sys_reset(sys_reset),
  .system_mgmt_interrupt_low(system_mgmt_interrupt_low), .expired(expired));
